// ---- otc_cmd_handler.sv ----
/*
   Command interpreter of the outdoor unit transmit chain: decodes the
   operational commands framed as E2 82 cmd [password] [step], answers
   each one with a response code, and drives the amplifier, transmitter
   supply, modulation and power step outputs.
   Assumes a byte receiver on ref_clk_in that flags parity per byte and
   strobes the end of each frame; alarm pins arrive asynchronously.
*/
`timescale 1ns/1ps
module otc_cmd_handler (
   input wire logic ref_clk_in,
   input wire logic srst_in,
   input wire logic [7:0] rx_byte_in,
   input wire logic rx_valid_in,
   input wire logic rx_parity_err_in,
   input wire logic rx_frame_end_in,
   output logic [7:0] tx_byte_out,
   output logic tx_valid_out,
   input wire logic tx_ready_in,
   input wire logic [7:0] access_password_in,
   input wire logic [7:0] factory_password_in,
   input wire logic opt_power_supported_in,
   input wire logic opt_mod_supported_in,
   input wire logic synth_unlock_in,
   input wire logic supply_fault_in,
   input wire logic self_test_fail_in,
   output logic output_amplifier_on_out,
   output logic tx_power_on_out,
   output logic mod_on_out,
   output logic [7:0] power_step_adjust_out,
   output logic power_step_stb_out,
   output logic locked_out,
   output logic [2:0] fail_count_out,
   output logic alarm_out
);
   import otc_pkg::*;

   // Command byte known to this handler
   function automatic logic cmd_known(input logic [7:0] c);
      cmd_known = (c == `OTC_CMD_AMP_ON) || (c == `OTC_CMD_AMP_OFF) ||
                  (c == `OTC_CMD_SET_PWR) || (c == `OTC_CMD_MOD_ON) ||
                  (c == `OTC_CMD_MOD_OFF) || (c == `OTC_CMD_TX_OFF) ||
                  (c == `OTC_CMD_TX_ON);
   endfunction

   // Command carries a password byte after the command byte
   function automatic logic cmd_has_pw(input logic [7:0] c);
      cmd_has_pw = (c == `OTC_CMD_AMP_ON) || (c == `OTC_CMD_TX_ON) ||
                   (c == `OTC_CMD_SET_PWR) || (c == `OTC_CMD_MOD_OFF);
   endfunction

   // Full frame length expected for a known command
   function automatic logic [2:0] cmd_len(input logic [7:0] c);
      if (c == `OTC_CMD_SET_PWR) begin
         cmd_len = `OTC_LEN_PWR;
      end else if (cmd_has_pw(c)) begin
         cmd_len = `OTC_LEN_PW;
      end else begin
         cmd_len = `OTC_LEN_BARE;
      end
   endfunction

   // Amplifier commands use the two-byte lock code, the rest one byte
   function automatic logic cmd_is_amp(input logic [7:0] c);
      cmd_is_amp = (c == `OTC_CMD_AMP_ON) || (c == `OTC_CMD_AMP_OFF);
   endfunction

   // Frame collector and reply sender links
   otc_frame_t frame;
   logic frame_valid;
   logic resp_idle;

   // Sequencer and verdict of the held frame
   otc_state_t state_ff;
   otc_state_t nxt_state;
   otc_resp_t rsp;
   logic ev_accept;
   logic ev_pw_bad;
   logic [7:0] cmd;
   logic [7:0] pw;
   logic [2:0] fail_next;
   logic evaluating;

   // Alarm synchroniser, two stages
   logic [2:0] alarm_meta_ff;
   logic [2:0] alarm_sync_ff;
   logic alarm;

   // Control state seen on the output pins
   logic amp_ff;
   logic tx_on_ff;
   logic mod_ff;
   logic locked_ff;
   logic [2:0] fail_cnt_ff;
   logic [7:0] step_ff;
   logic step_stb_ff;

   // Byte collection; the frame stays put until the evaluation cycle takes it
   otc_frame_rx u_frame_rx (
      .ref_clk_in(ref_clk_in),
      .srst_in(srst_in),
      .rx_byte_in(rx_byte_in),
      .rx_valid_in(rx_valid_in),
      .rx_parity_err_in(rx_parity_err_in),
      .rx_frame_end_in(rx_frame_end_in),
      .take_in(evaluating),
      .frame_out(frame),
      .frame_valid_out(frame_valid)
   );

   // Response bytes go out under the link handshake
   otc_resp_tx u_resp_tx (
      .ref_clk_in(ref_clk_in),
      .srst_in(srst_in),
      .resp_in(rsp),
      .load_in(evaluating),
      .tx_ready_in(tx_ready_in),
      .tx_byte_out(tx_byte_out),
      .tx_valid_out(tx_valid_out),
      .idle_out(resp_idle)
   );

   // Alarm pins are asynchronous; only the second stage feeds logic
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         alarm_meta_ff <= 3'h0;
         alarm_sync_ff <= 3'h0;
      end else begin
         alarm_meta_ff <= {self_test_fail_in, supply_fault_in, synth_unlock_in};
         alarm_sync_ff <= alarm_meta_ff;
      end
   end

   assign alarm = |alarm_sync_ff;

   // Sequencer: one frame is evaluated, then its reply drains before the next
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         OTC_ST_IDLE: begin
            if (frame_valid) begin
               nxt_state = OTC_ST_EVAL;
            end
         end
         OTC_ST_EVAL: begin
            nxt_state = OTC_ST_REPLY;
         end
         OTC_ST_REPLY: begin
            if (resp_idle) begin
               nxt_state = OTC_ST_IDLE;
            end
         end
         default: begin
            nxt_state = OTC_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         state_ff <= OTC_ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Fields by byte position; pw only means something for password commands
   assign evaluating = (state_ff == OTC_ST_EVAL);
   assign cmd = frame.data[2];
   assign pw = frame.data[3];
   assign fail_next = fail_cnt_ff + 3'h1;

   // Verdict on the held frame; earlier checks take priority over later ones
   always_comb begin
      rsp = '0;
      ev_accept = 1'b0;
      ev_pw_bad = 1'b0;
      // A corrupt byte makes every field doubtful, so parity is judged first
      if (frame.perr) begin
         rsp.b0 = `OTC_RSP_PARITY; // R6
      end else if (frame.ovf || (frame.len < `OTC_LEN_BARE) ||
                   (frame.data[0] != `OTC_HDR0) || (frame.data[1] != `OTC_HDR1)) begin
         rsp.b0 = `OTC_RSP_FORMAT; // R7
      end else if (!cmd_known(cmd)) begin
         rsp.b0 = `OTC_RSP_UNSUP; // R8
      end else if (frame.len != cmd_len(cmd)) begin
         rsp.b0 = `OTC_RSP_FORMAT; // R7
      end else if (((cmd == `OTC_CMD_SET_PWR) && !opt_power_supported_in) ||
                   (((cmd == `OTC_CMD_MOD_ON) || (cmd == `OTC_CMD_MOD_OFF)) &&
                    !opt_mod_supported_in)) begin
         rsp.b0 = `OTC_RSP_UNSUP; // R8
      end else if (locked_ff && (cmd != `OTC_CMD_TX_OFF)) begin
         // Transmitter-disable is the only command a locked unit obeys
         if (cmd_is_amp(cmd)) begin
            rsp.two = 1'b1; // R5
            rsp.b0 = `OTC_RSP_PW_HDR; // R13
            rsp.b1 = `OTC_RSP_PW_LOCK; // R5
         end else begin
            rsp.b0 = `OTC_RSP_LOCK1; // R19
         end
      end else if (cmd_has_pw(cmd) && (pw != access_password_in)) begin
         // Password checked before any action is taken
         ev_pw_bad = 1'b1; // R1
         rsp.two = 1'b1;
         rsp.b0 = `OTC_RSP_PW_HDR;
         if (fail_next == `OTC_FAIL_LOCK) begin
            rsp.b1 = `OTC_RSP_PW_LOCK; // R5
         end else if (fail_next == `OTC_FAIL_FIFTH) begin
            rsp.b1 = `OTC_RSP_PW_FIFTH; // R4
         end else begin
            rsp.b1 = {`OTC_RSP_PW_NIB, 1'b0, fail_next}; // R3
         end
      end else if ((cmd == `OTC_CMD_AMP_ON) &&
                   (access_password_in == factory_password_in)) begin
         // Default password still in place: refused without counting a failure
         rsp.two = 1'b1; // R9
         rsp.b0 = `OTC_RSP_PW_HDR;
         rsp.b1 = {`OTC_RSP_PW_NIB, 1'b0, fail_cnt_ff};
      end else begin
         // Acknowledged at once; amplifier settling is the host's timer
         ev_accept = 1'b1; // R11
         rsp.b0 = `OTC_RSP_ACCEPT; // R2
      end
   end

   // Consecutive failure count; an accepted password command clears it
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         fail_cnt_ff <= 3'h0;
      end else if (evaluating && ev_pw_bad) begin
         fail_cnt_ff <= fail_next; // R3
      end else if (evaluating && ev_accept && cmd_has_pw(cmd)) begin
         fail_cnt_ff <= 3'h0; // R23
      end
   end

   // Lock is sticky until reset, which stands for a power cycle here
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         locked_ff <= 1'b0;
      end else if (evaluating && ev_pw_bad && (fail_next == `OTC_FAIL_LOCK)) begin
         locked_ff <= 1'b1; // R5
      end
   end

   // Output amplifier; alarms win over any command in the same cycle
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         amp_ff <= `OTC_RST_AMP; // R14
      end else if (alarm) begin
         amp_ff <= 1'b0; // R17
      end else if (evaluating && ev_accept) begin
         if (cmd == `OTC_CMD_AMP_ON) begin
            amp_ff <= tx_on_ff; // R2
         end else if (cmd == `OTC_CMD_AMP_OFF) begin
            amp_ff <= 1'b0; // R13
         end else if (cmd == `OTC_CMD_TX_OFF) begin
            amp_ff <= 1'b0; // R15
         end else if (cmd == `OTC_CMD_TX_ON) begin
            amp_ff <= 1'b0; // R18
         end
      end
   end

   // Transmitter supply; disabling is honoured even when locked
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         tx_on_ff <= `OTC_RST_TX_ON;
      end else if (evaluating && ev_accept) begin
         if (cmd == `OTC_CMD_TX_OFF) begin
            tx_on_ff <= 1'b0; // R15
         end else if (cmd == `OTC_CMD_TX_ON) begin
            tx_on_ff <= 1'b1; // R18
         end
      end
   end

   // Modulation; off leaves a clean carrier on the output
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         mod_ff <= `OTC_RST_MOD_ON;
      end else if (evaluating && ev_accept) begin
         if (cmd == `OTC_CMD_MOD_ON) begin
            mod_ff <= 1'b1; // R21
         end else if (cmd == `OTC_CMD_MOD_OFF) begin
            mod_ff <= 1'b0; // R22
         end
      end
   end

   // Power step: signed count handed on with a one-cycle strobe
   // The step size in dB belongs to the analogue stage, not to this logic
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         step_ff <= 8'h00;
         step_stb_ff <= 1'b0;
      end else begin
         step_stb_ff <= 1'b0;
         if (evaluating && ev_accept && (cmd == `OTC_CMD_SET_PWR)) begin
            step_ff <= frame.data[4]; // R20
            step_stb_ff <= 1'b1; // R20
         end
      end
   end

   // Status and control outputs from flip-flops; alarm_out is the OR of the synchroniser flip-flops
   assign output_amplifier_on_out = amp_ff;
   assign tx_power_on_out = tx_on_ff;
   assign mod_on_out = mod_ff;
   assign power_step_adjust_out = step_ff;
   assign power_step_stb_out = step_stb_ff;
   assign locked_out = locked_ff;
   assign fail_count_out = fail_cnt_ff;
   assign alarm_out = alarm;
endmodule

// ---- otc_cfg.svh ----
/*
   Constants of the outdoor unit command handler: frame header, command
   codes, response codes, frame lengths, lockout counts and reset values.
   Assumes it is included by otc_pkg.sv and by the checker and testbench files.
*/
`ifndef OTC_CFG_SVH
`define OTC_CFG_SVH
// How it works
// R1: Amplifier-on is E2 82 C6 plus password; password checked before acting.
// R2: Accepted amplifier-on answers accept code and enables the output amplifier; the code enables it only while the transmitter is on.
// R3: Bad password below five failures answers ED then F0 plus count.
// R4: Fifth consecutive bad password answers ED FE.
// R5: Six or more failures lock; amplifier commands then answer ED FF.
// R6: Parity error answers E6 and nothing is executed.
// R7: Unrecognised frame format answers E7 and nothing is executed.
// R8: Unsupported command answers E5; set power and modulation are optional.
// R9: Amplifier-on refused while stored password equals factory default.
// R10: Host sends amplifier-on only when no alarm is present.
// R11: Correct amplifier-on is acknowledged at once, readiness comes later.
// R12: Host times readiness itself after the amplifier-on acknowledgement.
// R13: Amplifier-off C7, no password, accepts and disables; refused when locked.
// R14: Output amplifier is off after reset.
// R15: Transmitter-disable CE powers transmitter down, honoured even when locked.
// R16: Host disables transmitter in hold state, re-enables after hold ends.
// R17: Any alarm turns the amplifier off without a command.
// R18: Transmitter-enable CF with password powers transmitter, amplifier stays off.
// R19: Locked device rejects CF, C8, C9 and CA with one-byte EA.
// R20: Set power C8 plus password plus signed step byte adjusts power.
// R21: Modulation-on C9 re-enables modulation and answers accept code.
// R22: Modulation-off CA with password stops modulation, clean carrier results.
// R23: Correct password clears failure count; lock holds until reset. The code keeps the count when amplifier-on is refused for the factory password.
`define OTC_BYTE_W 8
`define OTC_FRAME_MAX 5
`define OTC_HDR0 8'hE2
`define OTC_HDR1 8'h82
`define OTC_CMD_AMP_ON 8'hC6
`define OTC_CMD_AMP_OFF 8'hC7
`define OTC_CMD_SET_PWR 8'hC8
`define OTC_CMD_MOD_ON 8'hC9
`define OTC_CMD_MOD_OFF 8'hCA
`define OTC_CMD_TX_OFF 8'hCE
`define OTC_CMD_TX_ON 8'hCF
`define OTC_LEN_BARE 3'h3
`define OTC_LEN_PW 3'h4
`define OTC_LEN_PWR 3'h5
`define OTC_RSP_ACCEPT 8'hE4
`define OTC_RSP_UNSUP 8'hE5
`define OTC_RSP_PARITY 8'hE6
`define OTC_RSP_FORMAT 8'hE7
`define OTC_RSP_LOCK1 8'hEA
`define OTC_RSP_PW_HDR 8'hED
`define OTC_RSP_PW_FIFTH 8'hFE
`define OTC_RSP_PW_LOCK 8'hFF
`define OTC_RSP_PW_NIB 4'hF
`define OTC_FAIL_FIFTH 3'h5
`define OTC_FAIL_LOCK 3'h6
`define OTC_RST_AMP 1'b0
`define OTC_RST_TX_ON 1'b1
`define OTC_RST_MOD_ON 1'b1
`endif

// ---- otc_pkg.sv ----
/*
   Types of the outdoor unit command handler: received frame, response
   and state codes. Assumes otc_cfg.svh sits in the include path.
*/
`include "otc_cfg.svh"
package otc_pkg;
   typedef enum logic [2:0] {
      OTC_ST_IDLE = 3'b001,
      OTC_ST_EVAL = 3'b010,
      OTC_ST_REPLY = 3'b100
   } otc_state_t;

   typedef struct packed {
      logic [2:0] len;
      logic ovf;
      logic perr;
      logic [`OTC_FRAME_MAX-1:0][`OTC_BYTE_W-1:0] data;
   } otc_frame_t;

   typedef struct packed {
      logic two;
      logic [`OTC_BYTE_W-1:0] b0;
      logic [`OTC_BYTE_W-1:0] b1;
   } otc_resp_t;
endpackage

// ---- otc_frame_rx.sv ----
/*
   Frame collector: gathers the bytes of one command frame until the
   frame end strobe and holds the frame until the interpreter takes it.
   Assumes byte strobes come from a receiver on the same clock.
*/
`timescale 1ns/1ps
module otc_frame_rx (
   input wire logic ref_clk_in,
   input wire logic srst_in,
   input wire logic [7:0] rx_byte_in,
   input wire logic rx_valid_in,
   input wire logic rx_parity_err_in,
   input wire logic rx_frame_end_in,
   input wire logic take_in,
   output otc_pkg::otc_frame_t frame_out,
   output logic frame_valid_out
);
   import otc_pkg::*;

   logic [`OTC_FRAME_MAX-1:0][7:0] data_ff;
   logic [2:0] cnt_ff;
   logic ovf_ff;
   logic perr_ff;
   logic held_ff;

   // Bytes arriving while a frame is held are dropped; host waits for the reply
   always_ff @(posedge ref_clk_in) begin
      if (srst_in || take_in) begin
         cnt_ff <= 3'h0;
         ovf_ff <= 1'b0;
         perr_ff <= 1'b0;
         held_ff <= 1'b0;
      end else if (!held_ff) begin
         if (rx_valid_in) begin
            if (cnt_ff < 3'(`OTC_FRAME_MAX)) begin
               data_ff[cnt_ff] <= rx_byte_in;
               cnt_ff <= cnt_ff + 3'h1;
            end else begin
               ovf_ff <= 1'b1; // Too long: reported as a format error
            end
            if (rx_parity_err_in) begin
               perr_ff <= 1'b1;
            end
         end
         if (rx_frame_end_in) begin
            held_ff <= 1'b1;
         end
      end
   end

   // Frame view, all from flip-flops
   assign frame_out = '{len: cnt_ff, ovf: ovf_ff, perr: perr_ff, data: data_ff};
   assign frame_valid_out = held_ff;
endmodule

// ---- otc_resp_tx.sv ----
/*
   Response sender: presents a one- or two-byte response code, one byte
   at a time, under a valid and ready handshake.
   Assumes the load strobe comes only while idle_out is high.
*/
`timescale 1ns/1ps
module otc_resp_tx (
   input wire logic ref_clk_in,
   input wire logic srst_in,
   input otc_pkg::otc_resp_t resp_in,
   input wire logic load_in,
   input wire logic tx_ready_in,
   output logic [7:0] tx_byte_out,
   output logic tx_valid_out,
   output logic idle_out
);
   import otc_pkg::*;

   logic [7:0] byte_ff;
   logic valid_ff;
   logic pend_ff;
   logic [7:0] second_ff;

   // First byte on load, second one after the first is taken
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         byte_ff <= 8'h00;
         valid_ff <= 1'b0;
         pend_ff <= 1'b0;
         second_ff <= 8'h00;
      end else if (load_in) begin
         byte_ff <= resp_in.b0;
         valid_ff <= 1'b1;
         pend_ff <= resp_in.two;
         second_ff <= resp_in.b1;
      end else if (valid_ff && tx_ready_in) begin
         if (pend_ff) begin
            byte_ff <= second_ff;
            pend_ff <= 1'b0;
         end else begin
            valid_ff <= 1'b0;
         end
      end
   end

   assign tx_byte_out = byte_ff;
   assign tx_valid_out = valid_ff;
   assign idle_out = !valid_ff;
endmodule

// ---- otc_cmd_handler_props.sv ----
/*
   Checker for the outdoor unit command handler: port-level relations of
   amplifier, transmitter, modulation, power step and lockout outputs.
   Assumes otc_cfg.svh on the include path and one clock domain.
*/
`timescale 1ns/1ps
`include "otc_cfg.svh"
module otc_cmd_handler_props (
   input wire logic ref_clk_in,
   input wire logic srst_in,
   input wire logic tx_ready_in,
   input wire logic [7:0] tx_byte_out,
   input wire logic tx_valid_out,
   input wire logic output_amplifier_on_out,
   input wire logic tx_power_on_out,
   input wire logic mod_on_out,
   input wire logic power_step_stb_out,
   input wire logic locked_out,
   input wire logic [2:0] fail_count_out,
   input wire logic alarm_out
);
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (srst_in);
   // Actions land on the same edge as the accept code load
   sequence ack_now;
      $rose(tx_valid_out) && tx_byte_out == `OTC_RSP_ACCEPT;
   endsequence
   amp_after_reset_a: assert property ($past(srst_in) |-> !output_amplifier_on_out)
      else $error("amplifier on right after reset");
   alarm_kills_amp_a: assert property (alarm_out |=> !output_amplifier_on_out)
      else $error("amplifier on while alarm");
   amp_on_ack_a: assert property ($rose(output_amplifier_on_out) |-> ack_now)
      else $error("amplifier rose without accept code");
   lock_at_six_a: assert property ($rose(locked_out) |-> fail_count_out == `OTC_FAIL_LOCK)
      else $error("lock without six failures");
   lock_sticky_a: assert property (locked_out |=> locked_out)
      else $error("lock released without reset");
   locked_amp_off_a: assert property (locked_out && !output_amplifier_on_out |=>
      !output_amplifier_on_out) else $error("amplifier turned on while locked");
   tx_on_amp_off_a: assert property ($rose(tx_power_on_out) |-> !output_amplifier_on_out)
      else $error("amplifier on with transmitter enable");
   tx_off_ack_a: assert property ($fell(tx_power_on_out) |-> ack_now)
      else $error("transmitter off without accept code");
   step_ack_a: assert property (power_step_stb_out |-> ack_now)
      else $error("power step without accept code");
   mod_ack_a: assert property (mod_on_out != $past(mod_on_out) |-> ack_now)
      else $error("modulation change without accept code");
   resp_hold_a: assert property (tx_valid_out && !tx_ready_in |=>
      tx_valid_out && $stable(tx_byte_out)) else $error("response byte dropped early");
   lock_cov: cover property ($rose(locked_out));
   amp_cov: cover property ($rose(output_amplifier_on_out));
   step_cov: cover property (power_step_stb_out);
endmodule
bind otc_cmd_handler otc_cmd_handler_props i_otc_cmd_handler_props (.ref_clk_in, .srst_in,
   .tx_ready_in, .tx_byte_out, .tx_valid_out, .output_amplifier_on_out, .tx_power_on_out,
   .mod_on_out, .power_step_stb_out, .locked_out, .fail_count_out, .alarm_out);

// ---- otc_host_model.sv ----
/*
   Indoor unit model: sends command frames byte by byte and takes the
   response bytes into a queue, promptly or with stalls.
   Assumes the handler's clock and the frame format of otc_cfg.svh.
*/
`timescale 1ns/1ps
module otc_host_model (
   input wire logic ref_clk_in,
   input wire logic slow_in,
   input wire logic [7:0] tx_byte_in,
   input wire logic tx_valid_in,
   output logic [7:0] rx_byte_out,
   output logic rx_valid_out,
   output logic rx_parity_err_out,
   output logic rx_frame_end_out,
   output logic tx_ready_out
);
   logic [7:0] rsp[$];
   initial begin
      rx_byte_out = 8'h00;
      rx_valid_out = 1'b0;
      rx_parity_err_out = 1'b0;
      rx_frame_end_out = 1'b0;
      tx_ready_out = 1'b1;
   end
   // Frame is header, command, password, step, first byte first
   task send(input logic [39:0] f, input int n, input int pe);
      for (int i = 0; i < n; i++) begin
         @(posedge ref_clk_in);
         rx_byte_out <= f[39-8*i -: 8];
         rx_valid_out <= 1'b1;
         rx_parity_err_out <= (i == pe);
         rx_frame_end_out <= (i == n - 1);
      end
      @(posedge ref_clk_in);
      // Idle byte lines show a changed value, never the last byte
      rx_byte_out <= ~rx_byte_out;
      rx_valid_out <= 1'b0;
      rx_parity_err_out <= 1'b0;
      rx_frame_end_out <= 1'b0;
   endtask
   // Take a byte on valid and ready; slow mode stalls every other cycle
   always @(posedge ref_clk_in) begin
      if (tx_valid_in && tx_ready_out)
         rsp.push_back(tx_byte_in);
      tx_ready_out <= slow_in ? (tx_valid_in && !tx_ready_out) : 1'b1;
   end
endmodule

// ---- testbench.sv ----
/*
   Self-checking bench of the command handler: each scenario sends
   frames through the host model and judges responses and outputs.
   Assumes otc_host_model and the checker bind are compiled with it.
*/
`timescale 1ns/1ps
`include "otc_cfg.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
   $display("MISMATCH %0t line %0d", $time, `__LINE__); end end
module testbench;
   import otc_pkg::*;
   logic ref_clk_in = 1'b0, srst_in = 1'b1, slow = 1'b0, opt_pwr = 1'b1, opt_mod = 1'b1;
   logic synth = 1'b0, supply = 1'b0, stest = 1'b0;
   logic [7:0] pw = 8'h5A, fpw = 8'hA5, rx_byte, tx_byte, step;
   logic rx_valid, rx_perr, rx_end, tx_valid, tx_ready, amp, txon, mod, stb, locked, alarm;
   logic [2:0] fails;
   int mismatches = 0, compares = 0, cyc = 0, stb_n = 0;
   localparam logic [7:0] BAD = 8'h00;
   initial forever #12.5 ref_clk_in = ~ref_clk_in;
   otc_host_model i_otc_host_model (.ref_clk_in(ref_clk_in), .slow_in(slow),
      .tx_byte_in(tx_byte), .tx_valid_in(tx_valid), .rx_byte_out(rx_byte),
      .rx_valid_out(rx_valid), .rx_parity_err_out(rx_perr), .rx_frame_end_out(rx_end),
      .tx_ready_out(tx_ready));
   otc_cmd_handler i_otc_cmd_handler (.ref_clk_in(ref_clk_in), .srst_in(srst_in),
      .rx_byte_in(rx_byte), .rx_valid_in(rx_valid), .rx_parity_err_in(rx_perr),
      .rx_frame_end_in(rx_end), .tx_byte_out(tx_byte), .tx_valid_out(tx_valid),
      .tx_ready_in(tx_ready), .access_password_in(pw), .factory_password_in(fpw),
      .opt_power_supported_in(opt_pwr), .opt_mod_supported_in(opt_mod),
      .synth_unlock_in(synth), .supply_fault_in(supply), .self_test_fail_in(stest),
      .output_amplifier_on_out(amp), .tx_power_on_out(txon), .mod_on_out(mod),
      .power_step_adjust_out(step), .power_step_stb_out(stb), .locked_out(locked),
      .fail_count_out(fails), .alarm_out(alarm));
   function automatic logic [39:0] fr(input logic [7:0] c, p, s);
      return {`OTC_HDR0, `OTC_HDR1, c, p, s};
   endfunction
   // One frame out, then wait under a bound for the expected reply bytes
   task run(input logic [39:0] f, input int n, input int pe, input logic [15:0] e, input int ne);
      int k;
      i_otc_host_model.rsp.delete();
      i_otc_host_model.send(f, n, pe);
      k = 0;
      while (i_otc_host_model.rsp.size() < ne && k < 30) begin
         @(posedge ref_clk_in);
         k++;
      end
      repeat (4) @(posedge ref_clk_in); // Late extra bytes would show here
      `CHK(i_otc_host_model.rsp.size(), ne)
      if (i_otc_host_model.rsp.size() > 0) `CHK(i_otc_host_model.rsp[0], e[15:8])
      if (i_otc_host_model.rsp.size() > 1) `CHK(i_otc_host_model.rsp[1], e[7:0])
   endtask
   task do_reset;
      srst_in <= 1'b1;
      repeat (6) @(posedge ref_clk_in);
      srst_in <= 1'b0;
      @(posedge ref_clk_in);
      `CHK({amp, txon, mod, locked, fails}, 7'b0110000)
   endtask
   task t_amp;
      run(fr(`OTC_CMD_AMP_ON, pw, 0), 4, 9, {`OTC_RSP_ACCEPT, 8'h00}, 1);
      `CHK(amp, 1'b1)
      run(fr(`OTC_CMD_AMP_OFF, 0, 0), 3, 2, {`OTC_RSP_PARITY, 8'h00}, 1);
      `CHK(amp, 1'b1)
      run(fr(`OTC_CMD_AMP_OFF, 0, 0), 4, 9, {`OTC_RSP_FORMAT, 8'h00}, 1);
      `CHK(amp, 1'b1)
      run(fr(`OTC_CMD_AMP_OFF, 0, 0), 3, 9, {`OTC_RSP_ACCEPT, 8'h00}, 1);
      `CHK(amp, 1'b0)
      run(fr(8'hD0, 0, 0), 3, 9, {`OTC_RSP_UNSUP, 8'h00}, 1);
      $display("t_amp done");
   endtask
   task t_options;
      opt_pwr <= 1'b0;
      opt_mod <= 1'b0;
      run(fr(`OTC_CMD_SET_PWR, pw, 8'h03), 5, 9, {`OTC_RSP_UNSUP, 8'h00}, 1);
      run(fr(`OTC_CMD_MOD_ON, 0, 0), 3, 9, {`OTC_RSP_UNSUP, 8'h00}, 1);
      opt_pwr <= 1'b1;
      opt_mod <= 1'b1;
      slow <= 1'b1;
      run(fr(`OTC_CMD_SET_PWR, pw, 8'h80), 5, 9, {`OTC_RSP_ACCEPT, 8'h00}, 1);
      `CHK(step, 8'h80)
      `CHK(stb_n, 1)
      run(fr(`OTC_CMD_MOD_OFF, pw, 0), 4, 9, {`OTC_RSP_ACCEPT, 8'h00}, 1);
      `CHK(mod, 1'b0)
      run(fr(`OTC_CMD_MOD_ON, 0, 0), 3, 9, {`OTC_RSP_ACCEPT, 8'h00}, 1);
      `CHK(mod, 1'b1)
      slow <= 1'b0;
      $display("t_options done");
   endtask
   task t_tx_alarm;
      logic [2:0] al;
      run(fr(`OTC_CMD_TX_OFF, 0, 0), 3, 9, {`OTC_RSP_ACCEPT, 8'h00}, 1);
      `CHK(txon, 1'b0)
      run(fr(`OTC_CMD_AMP_ON, pw, 0), 4, 9, {`OTC_RSP_ACCEPT, 8'h00}, 1);
      `CHK(amp, 1'b0)
      run(fr(`OTC_CMD_TX_ON, pw, 0), 4, 9, {`OTC_RSP_ACCEPT, 8'h00}, 1);
      `CHK({txon, amp}, 2'b10)
      // Each alarm pin in turn must switch a running amplifier off
      for (int i = 0; i < 3; i++) begin
         run(fr(`OTC_CMD_AMP_ON, pw, 0), 4, 9, {`OTC_RSP_ACCEPT, 8'h00}, 1);
         al = 3'b001 << i;
         {synth, supply, stest} <= al;
         repeat (5) @(posedge ref_clk_in);
         `CHK({amp, alarm}, 2'b01)
         {synth, supply, stest} <= 3'b000;
         repeat (5) @(posedge ref_clk_in);
      end
      fpw <= pw;
      run(fr(`OTC_CMD_AMP_ON, pw, 0), 4, 9, {`OTC_RSP_PW_HDR, 8'hF0}, 2);
      `CHK(amp, 1'b0)
      fpw <= 8'hA5;
      $display("t_tx_alarm done");
   endtask
   task t_lock;
      for (int i = 1; i <= 4; i++)
         run(fr(`OTC_CMD_AMP_ON, BAD, 0), 4, 9, {`OTC_RSP_PW_HDR, 8'hF0 | i[7:0]}, 2);
      run(fr(`OTC_CMD_TX_ON, pw, 0), 4, 9, {`OTC_RSP_ACCEPT, 8'h00}, 1);
      `CHK(fails, 3'h0)
      for (int i = 1; i <= 4; i++)
         run(fr(`OTC_CMD_MOD_OFF, BAD, 0), 4, 9, {`OTC_RSP_PW_HDR, 8'hF0 | i[7:0]}, 2);
      run(fr(`OTC_CMD_AMP_ON, BAD, 0), 4, 9, {`OTC_RSP_PW_HDR, `OTC_RSP_PW_FIFTH}, 2);
      `CHK(locked, 1'b0)
      run(fr(`OTC_CMD_AMP_ON, BAD, 0), 4, 9, {`OTC_RSP_PW_HDR, `OTC_RSP_PW_LOCK}, 2);
      `CHK({locked, fails}, 4'hE)
      run(fr(`OTC_CMD_AMP_ON, pw, 0), 4, 9, {`OTC_RSP_PW_HDR, `OTC_RSP_PW_LOCK}, 2);
      run(fr(`OTC_CMD_AMP_OFF, 0, 0), 3, 9, {`OTC_RSP_PW_HDR, `OTC_RSP_PW_LOCK}, 2);
      run(fr(`OTC_CMD_TX_ON, pw, 0), 4, 9, {`OTC_RSP_LOCK1, 8'h00}, 1);
      run(fr(`OTC_CMD_SET_PWR, pw, 8'h7F), 5, 9, {`OTC_RSP_LOCK1, 8'h00}, 1);
      `CHK(stb_n, 1)
      run(fr(`OTC_CMD_MOD_ON, 0, 0), 3, 9, {`OTC_RSP_LOCK1, 8'h00}, 1);
      run(fr(`OTC_CMD_MOD_OFF, pw, 0), 4, 9, {`OTC_RSP_LOCK1, 8'h00}, 1);
      run(fr(`OTC_CMD_TX_OFF, 0, 0), 3, 9, {`OTC_RSP_ACCEPT, 8'h00}, 1);
      `CHK({txon, locked, amp}, 3'b010)
      $display("t_lock done");
   endtask
   task end_sim;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // A hang is cut short well beyond the few hundred cycles the tests need
   always @(posedge ref_clk_in) begin
      cyc++;
      if (stb) stb_n++;
      if (cyc == 20000) begin
         mismatches++;
         end_sim();
      end
   end
   initial begin
      do_reset();
      t_amp();
      t_options();
      t_tx_alarm();
      t_lock();
      do_reset();
      end_sim();
   end
endmodule
